// ### bench/line_partner.sv
// far-side model: receive event strobes, alarm levels and transmit byte slots
// assumes one clock shared with the register bank, all changes just after an edge
`timescale 1ns/1ps
`default_nettype none
module line_partner (
  // clock
  input  wire logic                   core_clk_in,
  // toward the bank
  output var sonet_ovh_pkg::rx_event_t rx_event_out,
  output var sonet_ovh_pkg::tx_slot_t  tx_slot_out,
  output var sonet_ovh_pkg::tx_byte_t  tx_data_out,
  // from the bank
  input  wire sonet_ovh_pkg::tx_byte_t line_byte_in
);
  import sonet_ovh_pkg::*;

  initial begin
    rx_event_out = '0;
    tx_slot_out  = '0;
    tx_data_out  = '0;
  end

  // one frame's count: 0 section, 1 line parity, 2 far-end; counts scrambled once invalid
  task automatic strobe(input int kind, input logic [4:0] n);
    @(posedge core_clk_in);
    rx_event_out.b1_valid   <= (kind == 0);
    rx_event_out.b2_valid   <= (kind == 1);
    rx_event_out.febe_valid <= (kind == 2);
    rx_event_out.b1_count   <= n[3:0];
    rx_event_out.b2_count   <= n;
    rx_event_out.febe_count <= n;
    @(posedge core_clk_in);
    rx_event_out.b1_valid   <= 1'b0;
    rx_event_out.b2_valid   <= 1'b0;
    rx_event_out.febe_valid <= 1'b0;
    rx_event_out.b1_count   <= ~n[3:0];
    rx_event_out.b2_count   <= ~n;
    rx_event_out.febe_count <= ~n;
  endtask : strobe

  task automatic set_states(input logic rdi, input logic ais);
    @(posedge core_clk_in);
    rx_event_out.rdi_state <= rdi;
    rx_event_out.ais_state <= ais;
  endtask : set_states

  // one byte in, the bank's registered byte back one cycle later
  task automatic send_byte(input tx_slot_t s, input logic [7:0] d, output logic [7:0] got);
    @(posedge core_clk_in);
    tx_slot_out <= s;
    tx_data_out <= {1'b1, d};
    @(posedge core_clk_in);
    tx_slot_out <= ~s;
    tx_data_out <= {1'b0, ~d};
    #1;
    got = line_byte_in.data;
  endtask : send_byte
endmodule : line_partner
`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the overhead register bank
// assumes the params header and package are compiled first
`include "sonet_ovh_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sonet_ovh_pkg::*;
  logic        core_clk_in = 1'b0;
  logic        sys_rst_in  = 1'b1;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [7:0]  paddr       = 8'h00;
  logic [31:0] pwdata      = 32'h00000000;
  logic        clk_en      = 1'b1;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [31:0] prdata;
  rx_event_t   rx_event;
  tx_slot_t    tx_slot;
  tx_byte_t    tx_in;
  tx_byte_t    tx_out;
  int          fail_count      = 0;
  int          samples_checked = 0;
  localparam tx_slot_t a1_slot  = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 5'h00};
  localparam tx_slot_t c1_slot  = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 5'h02};
  localparam tx_slot_t pay_slot = '0;
  localparam tx_slot_t b1_slot  = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 5'h00};

  always #10 core_clk_in = ~core_clk_in;

  sonet_section_line_overhead_regs dut_u (
    .core_clk_in (core_clk_in), .sys_rst_in (sys_rst_in), .clk_en_in (clk_en),
    .psel_in (psel), .penable_in (penable), .pwrite_in (pwrite), .paddr_in (paddr),
    .pwdata_in (pwdata), .pstrb_in (4'hF), .pready_out (pready), .pslverr_out (pslverr),
    .prdata_out (prdata), .rx_event_in (rx_event), .tx_slot_in (tx_slot),
    .tx_byte_in (tx_in), .tx_byte_out (tx_out), .irq_out (irq)
  );

  line_partner line_u (
    .core_clk_in (core_clk_in), .rx_event_out (rx_event), .tx_slot_out (tx_slot),
    .tx_data_out (tx_in), .line_byte_in (tx_out)
  );

  task automatic end_sim;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic miss(input string m);
    fail_count++;
    $display("ERROR %0t %s", $time, m);
  endtask : miss

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) miss($sformatf("byte %h expected %h", got, exp));
  endtask : check8

  task automatic check1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) miss($sformatf("bit %b expected %b", got, exp));
  endtask : check1

  // one apb transfer; holds everything until pready is seen high
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd, output logic err);
    int n;
    @(posedge core_clk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge core_clk_in);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk_in);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      miss("no pready");
      end_sim();
    end
    rd      = prdata[7:0];
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] rd;
    logic       err;
    apb(1'b1, idx, d, rd, err);
  endtask : wr

  task automatic rd(input logic [5:0] idx, output logic [7:0] v);
    logic err;
    apb(1'b0, idx, 8'h00, v, err);
  endtask : rd

  task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    rd(idx, v);
    check8(v, exp);
  endtask : rdchk

  task automatic wait_irq(input logic exp);
    for (int n = 0; n < 10; n++) begin
      @(posedge core_clk_in);
      #1;
      if (irq === exp) break;
    end
    check1(irq, exp);
    if (irq !== exp) end_sim();
  endtask : wait_irq

  task automatic tx_chk(input tx_slot_t s, input logic [7:0] d, input logic [7:0] exp);
    logic [7:0] got;
    line_u.send_byte(s, d, got);
    check8(got, exp);
    check1(tx_out.valid, 1'b1);
  endtask : tx_chk

  task automatic sc_reset;
    logic [7:0] v;
    logic       err;
    rdchk(`IDX_TX_SECT_CTL, 8'h00);
    rdchk(`IDX_TX_SECT_DIAG, 8'h00);
    rdchk(`IDX_RX_LINE_CTL, 8'h00);
    rdchk(`IDX_RX_LINE_IRQ, 8'h00);
    rdchk(`IDX_LINE_ERR_HI, 8'h00);
    apb(1'b0, 6'h30, 8'h00, v, err);
    check1(err, 1'b1);
    check8(v, 8'h00);
  endtask : sc_reset

  task automatic sc_section;
    logic [7:0] a;
    logic [7:0] b;
    // 20 frames of 15 errors: 300 spans both bytes
    for (int i = 0; i < 20; i++) line_u.strobe(0, 5'd15);
    wr(`IDX_SECT_ERR_HI, 8'h00);
    rdchk(`IDX_SECT_ERR_LO, 8'h2C);
    rdchk(`IDX_SECT_ERR_HI, 8'h01);
    // event lands on the poll's commit edge
    fork
      wr(`IDX_SECT_ERR_LO, 8'h00);
      begin
        @(posedge core_clk_in);
        line_u.strobe(0, 5'd7);
      end
    join
    rd(`IDX_SECT_ERR_LO, a);
    wr(`IDX_SECT_ERR_LO, 8'h00);
    rd(`IDX_SECT_ERR_LO, b);
    check8(a + b, 8'h07);
  endtask : sc_section

  task automatic sc_master;
    line_u.strobe(0, 5'd2);
    line_u.strobe(1, 5'd3);
    line_u.strobe(2, 5'd4);
    wr(`IDX_MASTER_LOAD, 8'h00);
    rdchk(`IDX_SECT_ERR_LO, 8'h02);
    rdchk(`IDX_LINE_ERR_LO, 8'h03);
    rdchk(`IDX_FEBE_ERR_LO, 8'h04);
  endtask : sc_master

  task automatic sc_word;
    line_u.strobe(1, 5'd24);
    wr(`IDX_LINE_ERR_MID, 8'h00);
    rdchk(`IDX_LINE_ERR_LO, 8'h18);
    wr(`IDX_RX_LINE_CTL, 8'h80);
    line_u.strobe(1, 5'd5);
    line_u.strobe(1, 5'd5);
    wr(`IDX_FEBE_ERR_HI, 8'h00);
    rdchk(`IDX_LINE_ERR_LO, 8'h02);
    rdchk(`IDX_LINE_ERR_HI, 8'h00);
  endtask : sc_word

  task automatic sc_irq;
    rdchk(`IDX_RX_LINE_IRQ, 8'h0C);
    rdchk(`IDX_RX_LINE_IRQ, 8'h00);
    line_u.set_states(1'b1, 1'b0);
    repeat (4) @(posedge core_clk_in);
    check1(irq, 1'b0);
    rdchk(`IDX_RX_LINE_CTL, 8'h81);
    rdchk(`IDX_RX_LINE_IRQ, 8'h01);
    wr(`IDX_RX_LINE_IRQ, 8'hF0);
    line_u.set_states(1'b1, 1'b1);
    wait_irq(1'b1);
    rdchk(`IDX_RX_LINE_CTL, 8'h83);
    rdchk(`IDX_RX_LINE_IRQ, 8'hF2);
    wait_irq(1'b0);
    rdchk(`IDX_RX_LINE_IRQ, 8'hF0);
    wr(`IDX_RX_LINE_IRQ, 8'h10);
    line_u.strobe(1, 5'd1);
    repeat (4) @(posedge core_clk_in);
    check1(irq, 1'b0);
    line_u.set_states(1'b0, 1'b1);
    wait_irq(1'b1);
    rdchk(`IDX_RX_LINE_IRQ, 8'h15);
    wait_irq(1'b0);
  endtask : sc_irq

  task automatic sc_tx;
    wr(`IDX_TX_SECT_CTL, 8'h40);
    tx_chk(a1_slot, 8'hF6, 8'hF6);
    tx_chk(c1_slot, 8'h55, 8'h02);
    tx_chk(pay_slot, 8'h3C, 8'h3C);
    wr(`IDX_TX_SECT_DIAG, 8'h08);
    tx_chk(c1_slot, 8'h55, 8'h55);
    wr(`IDX_TX_SECT_DIAG, 8'h01);
    tx_chk(a1_slot, 8'hF6, 8'h76);
    wr(`IDX_TX_SECT_DIAG, 8'h04);
    tx_chk(c1_slot, 8'h55, 8'h00);
    wr(`IDX_TX_SECT_DIAG, 8'h00);
    // insertion waits for the next frame start, in both directions
    wr(`IDX_TX_SECT_CTL, 8'h41);
    tx_chk(pay_slot, 8'h3C, 8'h3C);
    tx_chk(a1_slot, 8'hF6, 8'hF6);
    tx_chk(c1_slot, 8'h55, 8'h02);
    tx_chk(pay_slot, 8'h3C, 8'hFF);
    wr(`IDX_TX_SECT_CTL, 8'h40);
    tx_chk(pay_slot, 8'h3C, 8'hFF);
    tx_chk(a1_slot, 8'hF6, 8'hF6);
    tx_chk(pay_slot, 8'h3C, 8'h3C);
    // parity byte carries the previous frame's parity: F6^3C inverted by the B1 inject, then F6^35
    tx_chk(a1_slot, 8'hF6, 8'hF6);
    tx_chk(pay_slot, 8'h3C, 8'h3C);
    wr(`IDX_TX_SECT_DIAG, 8'h02);
    tx_chk(a1_slot, 8'hF6, 8'hF6);
    tx_chk(b1_slot, 8'h00, 8'h35);
    wr(`IDX_TX_SECT_DIAG, 8'h00);
    tx_chk(a1_slot, 8'hF6, 8'hF6);
    tx_chk(b1_slot, 8'h00, 8'hC3);
    // all-ones seed at frame start: second key byte is 04
    wr(`IDX_TX_SECT_CTL, 8'h00);
    tx_chk(a1_slot, 8'hF6, 8'hF6);
    tx_chk(pay_slot, 8'h00, 8'h04);
  endtask : sc_tx

  // frozen clock enable: no count, no ready
  task automatic sc_freeze;
    @(posedge core_clk_in);
    clk_en <= 1'b0;
    line_u.strobe(0, 5'd5);
    check1(pready, 1'b0);
    @(posedge core_clk_in);
    clk_en <= 1'b1;
    wr(`IDX_SECT_ERR_LO, 8'h00);
    rdchk(`IDX_SECT_ERR_LO, 8'h00);
  endtask : sc_freeze

  initial begin
    repeat (10) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    sc_reset();
    sc_section();
    sc_master();
    sc_word();
    sc_irq();
    sc_tx();
    sc_freeze();
    end_sim();
  end
endmodule : tb
`default_nettype wire

// ### rtl/sonet_ovh_params.svh
// register indices, field positions, reset values and timing counts for the
// section/line overhead register bank; definitions only
`ifndef SONET_OVH_PARAMS_SVH
`define SONET_OVH_PARAMS_SVH

// register indices; the byte address on the bus is four times the index
`define IDX_MASTER_LOAD   6'h00
`define IDX_SECT_ERR_LO   6'h12
`define IDX_SECT_ERR_HI   6'h13
`define IDX_TX_SECT_CTL   6'h14
`define IDX_TX_SECT_DIAG  6'h15
`define IDX_RX_LINE_CTL   6'h18
`define IDX_RX_LINE_IRQ   6'h19
`define IDX_LINE_ERR_LO   6'h1A
`define IDX_LINE_ERR_MID  6'h1B
`define IDX_LINE_ERR_HI   6'h1C
`define IDX_FEBE_ERR_LO   6'h1D
`define IDX_FEBE_ERR_MID  6'h1E
`define IDX_FEBE_ERR_HI   6'h1F

// field positions
`define TXC_SCR_DIS_BIT   6
`define TXC_AIS_BIT       0
`define DIAG_ZERO_BIT     2
`define DIAG_B1_BIT       1
`define DIAG_FP_BIT       0
`define DIAG_C1_BIT       3
`define RLC_WORD_BIT      7
`define RLC_AIS_BIT       1
`define RLC_RDI_BIT       0
`define IRQ_EN_LSB        4

// reset values
`define TX_SECT_CTL_RST   8'h00
`define TX_SECT_DIAG_RST  8'h00
`define RX_LINE_CTL_RST   8'h00
`define LINE_IRQ_RST      4'h0
`define SECT_CNT_RST      16'h0000
`define LINE_CNT_RST      20'h00000

// framing byte values
`define A1_GOOD           8'hF6
`define A1_BAD            8'h76
`define SCR_SEED          7'h7F
`define AIS_FILL          8'hFF

// timing: longest allowed snapshot delay, rounded down to cycles
`define CLK_PERIOD_NS     20
`define POLL_TIME_NS      7000
`define POLL_CYCLES       (`POLL_TIME_NS / `CLK_PERIOD_NS)

`endif

// ### rtl/sonet_ovh_pkg.sv
// types shared by the overhead register bank and its bench
// assumes the params header is compiled alongside
package sonet_ovh_pkg;

  // receive-side events from the section and line processors
  typedef struct packed {
    logic       b1_valid;
    logic [3:0] b1_count;
    logic       b2_valid;
    logic [4:0] b2_count;
    logic       febe_valid;
    logic [4:0] febe_count;
    logic       rdi_state;
    logic       ais_state;
  } rx_event_t;

  // position of the current transmit byte within the frame
  typedef struct packed {
    logic       frame_start;
    logic       soh;
    logic       a1;
    logic       b1;
    logic       c1;
    logic       unscrambled;
    logic [4:0] sts_index;
  } tx_slot_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } tx_byte_t;

  // line interrupt bits, same order as the low nibble of the irq register
  typedef struct packed {
    logic febe;
    logic b2;
    logic ais;
    logic rdi;
  } line_irq_t;

endpackage : sonet_ovh_pkg

// ### rtl/sonet_section_line_overhead_regs.sv
// section and line overhead register bank with transmit overhead insertion
// assumes an apb master on the same clock, and frame-aligned byte strobes
// from the receive processors and the transmit byte pipeline
//
// Chosen here: the APB slave port.
`include "sonet_ovh_params.svh"
`timescale 1ns/1ps
`default_nettype none

module sonet_section_line_overhead_regs (
  // clock, reset, enable
  input  wire logic                   core_clk_in,
  input  wire logic                   sys_rst_in,
  input  wire logic                   clk_en_in,
  // apb slave
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [7:0]             paddr_in,
  input  wire logic [31:0]            pwdata_in,
  input  wire logic [3:0]             pstrb_in,
  output logic                        pready_out,
  output logic                        pslverr_out,
  output logic [31:0]                 prdata_out,
  // receive events
  input  wire sonet_ovh_pkg::rx_event_t rx_event_in,
  // transmit stream
  input  wire sonet_ovh_pkg::tx_slot_t  tx_slot_in,
  input  wire sonet_ovh_pkg::tx_byte_t  tx_byte_in,
  output sonet_ovh_pkg::tx_byte_t       tx_byte_out,
  // interrupt
  output logic                        irq_out
);
  import sonet_ovh_pkg::*;

  logic [7:0]  tx_sect_ctl;
  logic [7:0]  tx_sect_diag;
  logic [7:0]  rx_line_ctl;
  line_irq_t   irq_status;
  line_irq_t   irq_enable;
  line_irq_t   rd_irq_mask;
  line_irq_t   next_irq_status;
  line_irq_t   irq_events;
  logic [15:0] section_acc;
  logic [19:0] line_acc;
  logic [19:0] febe_acc;
  logic [15:0] section_parity_error_count;
  logic [19:0] line_parity_error_count;
  logic [19:0] line_far_end_error_count;
  logic [15:0] sect_sum;
  logic [19:0] sect_sum_wide;
  line_irq_t   next_irq_enable;
  logic [19:0] b2_sum;
  logic [19:0] febe_sum;
  logic [4:0]  b2_inc;
  logic        rdi_prev;
  logic        ais_prev;
  logic [5:0]  idx;
  logic        mapped;
  logic        setup_rd;
  logic        acc_done;
  logic        wr_done;
  logic        sect_poll;
  logic        line_poll;
  logic        master_poll;
  logic [7:0]  rd_byte;
  logic        ais_active;
  logic        ais_now;
  logic [6:0]  scr_state;
  logic [6:0]  next_scr_state;
  logic [7:0]  scr_key;
  logic [7:0]  pre_byte;
  logic [7:0]  scr_byte;
  logic [7:0]  bip_acc;
  logic [7:0]  bip_prev;

  wire line_alarm_insert          = tx_sect_ctl[`TXC_AIS_BIT];
  wire tx_scramble_disable        = tx_sect_ctl[`TXC_SCR_DIS_BIT];
  wire all_zero_inject            = tx_sect_diag[`DIAG_ZERO_BIT];
  wire section_parity_error_inject = tx_sect_diag[`DIAG_B1_BIT];
  wire framing_error_inject       = tx_sect_diag[`DIAG_FP_BIT];
  wire identity_overwrite_disable = tx_sect_diag[`DIAG_C1_BIT];
  wire b2_word_count_mode         = rx_line_ctl[`RLC_WORD_BIT];

  // saturating add; a wrapped count would read as few errors
  function automatic logic [19:0] sat_add(input logic [19:0] acc, input logic [4:0] inc,
                                          input logic [19:0] max);
    logic [20:0] sum;
    sum = {1'b0, acc} + {16'h0000, inc};
    if (sum > {1'b0, max}) begin
      sat_add = max;
    end else begin
      sat_add = sum[19:0];
    end
  endfunction : sat_add

  // apb decode; zero wait states, stalled only by the clock enable
  assign idx        = paddr_in[7:2];
  assign mapped     = (idx == `IDX_MASTER_LOAD) ||
                      (idx >= `IDX_SECT_ERR_LO && idx <= `IDX_TX_SECT_DIAG) ||
                      (idx >= `IDX_RX_LINE_CTL && idx <= `IDX_FEBE_ERR_HI);
  assign pready_out  = clk_en_in;
  assign pslverr_out = psel_in && penable_in && !mapped;
  assign setup_rd    = clk_en_in && psel_in && !penable_in && !pwrite_in;
  assign acc_done    = clk_en_in && psel_in && penable_in && mapped;
  assign wr_done     = acc_done && pwrite_in;
  assign master_poll = wr_done && (idx == `IDX_MASTER_LOAD);
  assign sect_poll   = master_poll || (wr_done && (idx == `IDX_SECT_ERR_LO ||
                                                   idx == `IDX_SECT_ERR_HI));
  assign line_poll   = master_poll || (wr_done && idx >= `IDX_LINE_ERR_LO &&
                                       idx <= `IDX_FEBE_ERR_HI);

  always_comb begin
    case (idx)
      `IDX_SECT_ERR_LO:  rd_byte = section_parity_error_count[7:0];
      `IDX_SECT_ERR_HI:  rd_byte = section_parity_error_count[15:8];
      `IDX_TX_SECT_CTL:  rd_byte = tx_sect_ctl;
      `IDX_TX_SECT_DIAG: rd_byte = tx_sect_diag;
      `IDX_RX_LINE_CTL:  rd_byte = {rx_line_ctl[7:3], 1'b0, rx_event_in.ais_state,
                                    rx_event_in.rdi_state};
      `IDX_RX_LINE_IRQ:  rd_byte = {irq_enable, irq_status};
      `IDX_LINE_ERR_LO:  rd_byte = line_parity_error_count[7:0];
      `IDX_LINE_ERR_MID: rd_byte = line_parity_error_count[15:8];
      `IDX_LINE_ERR_HI:  rd_byte = {4'h0, line_parity_error_count[19:16]};
      `IDX_FEBE_ERR_LO:  rd_byte = line_far_end_error_count[7:0];
      `IDX_FEBE_ERR_MID: rd_byte = line_far_end_error_count[15:8];
      `IDX_FEBE_ERR_HI:  rd_byte = {4'h0, line_far_end_error_count[19:16]};
      default:           rd_byte = 8'h00;
    endcase
  end

  // read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      prdata_out  <= 32'h00000000;
      rd_irq_mask <= `LINE_IRQ_RST;
    end else if (setup_rd) begin
      prdata_out  <= {24'h000000, rd_byte};
      rd_irq_mask <= (idx == `IDX_RX_LINE_IRQ) ? irq_status : `LINE_IRQ_RST;
    end
  end

  // control registers; only byte lane 0 carries data
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      tx_sect_ctl  <= `TX_SECT_CTL_RST;
      tx_sect_diag <= `TX_SECT_DIAG_RST;
      rx_line_ctl  <= `RX_LINE_CTL_RST;
      irq_enable   <= `LINE_IRQ_RST;
    end else if (wr_done && pstrb_in[0]) begin
      case (idx)
        `IDX_TX_SECT_CTL:  tx_sect_ctl  <= pwdata_in[7:0] & 8'h7F;
        `IDX_TX_SECT_DIAG: tx_sect_diag <= pwdata_in[7:0] & 8'h0F;
        `IDX_RX_LINE_CTL:  rx_line_ctl  <= {pwdata_in[7:3], 3'b000};
        `IDX_RX_LINE_IRQ:  irq_enable   <= pwdata_in[7:4];
        default:           irq_enable   <= irq_enable;
      endcase
    end
  end

  // error counting; the incoming event is folded into the snapshot
  // bit mode adds bit count
  // word mode adds one per frame with a nonzero count
  assign b2_inc   = (b2_word_count_mode && rx_event_in.b2_count != 5'h00) ? 5'h01
                                                                        : rx_event_in.b2_count;
  assign sect_sum_wide = sat_add({4'h0, section_acc},
                                 rx_event_in.b1_valid ? {1'b0, rx_event_in.b1_count} : 5'h00,
                                 20'h0FFFF);
  assign sect_sum      = sect_sum_wide[15:0];
  assign b2_sum   = sat_add(line_acc, rx_event_in.b2_valid ? b2_inc : 5'h00, 20'hFFFFF);
  assign febe_sum = sat_add(febe_acc, rx_event_in.febe_valid ? rx_event_in.febe_count : 5'h00,
                            20'hFFFFF);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      section_acc                <= `SECT_CNT_RST;
      section_parity_error_count <= `SECT_CNT_RST;
    end else if (clk_en_in) begin
      if (sect_poll) begin
        section_parity_error_count <= sect_sum;
        section_acc                <= `SECT_CNT_RST;
      end else begin
        section_acc <= sect_sum;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      line_acc                 <= `LINE_CNT_RST;
      febe_acc                 <= `LINE_CNT_RST;
      line_parity_error_count  <= `LINE_CNT_RST;
      line_far_end_error_count <= `LINE_CNT_RST;
    end else if (clk_en_in) begin
      if (line_poll) begin
        line_parity_error_count  <= b2_sum;
        line_far_end_error_count <= febe_sum;
        line_acc                 <= `LINE_CNT_RST;
        febe_acc                 <= `LINE_CNT_RST;
      end else begin
        line_acc <= b2_sum;
        febe_acc <= febe_sum;
      end
    end
  end

  // line interrupt status; a set in the clearing cycle wins
  always_comb begin
    irq_events.rdi  = rx_event_in.rdi_state != rdi_prev;
    irq_events.ais  = rx_event_in.ais_state != ais_prev;
    irq_events.b2   = rx_event_in.b2_valid && rx_event_in.b2_count != 5'h00;
    irq_events.febe = rx_event_in.febe_valid && rx_event_in.febe_count != 5'h00;
    next_irq_status = irq_status;
    if (acc_done && !pwrite_in && idx == `IDX_RX_LINE_IRQ) begin
      next_irq_status = irq_status & ~rd_irq_mask;
    end
    next_irq_status = next_irq_status | irq_events;
  end

  // an enable written this cycle gates irq together with the new status
  assign next_irq_enable = (wr_done && pstrb_in[0] && idx == `IDX_RX_LINE_IRQ) ? pwdata_in[7:4]
                                                                              : irq_enable;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      irq_status <= `LINE_IRQ_RST;
      rdi_prev   <= 1'b0;
      ais_prev   <= 1'b0;
      irq_out    <= 1'b0;
    end else if (clk_en_in) begin
      irq_status <= next_irq_status;
      rdi_prev   <= rx_event_in.rdi_state;
      ais_prev   <= rx_event_in.ais_state;
      irq_out    <= |(next_irq_status & next_irq_enable);
    end
  end

  // transmit overhead insertion and scrambling
  // alarm insert switches only at frame start
  assign ais_now = tx_slot_in.frame_start ? line_alarm_insert : ais_active;

  always_comb begin
    next_scr_state = tx_slot_in.frame_start ? `SCR_SEED : scr_state;
    for (int i = 7; i >= 0; i--) begin
      scr_key[i]     = next_scr_state[6];
      next_scr_state = {next_scr_state[5:0], next_scr_state[6] ^ next_scr_state[5]};
    end
    pre_byte = tx_byte_in.data;
    if (ais_now && !tx_slot_in.soh) begin
      pre_byte = `AIS_FILL;
    end
    if (tx_slot_in.c1 && !identity_overwrite_disable) begin
      pre_byte = {3'b000, tx_slot_in.sts_index};
    end
    if (tx_slot_in.a1) begin
      pre_byte = framing_error_inject ? `A1_BAD : `A1_GOOD;
    end
    if (tx_slot_in.b1) begin
      pre_byte = section_parity_error_inject ? ~bip_prev : bip_prev;
    end
    scr_byte = (tx_scramble_disable || tx_slot_in.unscrambled) ? pre_byte
                                                               : pre_byte ^ scr_key;
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ais_active  <= 1'b0;
      scr_state   <= `SCR_SEED;
      bip_acc     <= 8'h00;
      bip_prev    <= 8'h00;
      tx_byte_out <= '0;
    end else if (clk_en_in) begin
      tx_byte_out.valid <= tx_byte_in.valid;
      if (tx_byte_in.valid) begin
        ais_active <= ais_now;
        scr_state  <= next_scr_state;
        // parity over scrambled bytes feeds the next frame's B1
        if (tx_slot_in.frame_start) begin
          bip_prev <= bip_acc;
          bip_acc  <= scr_byte;
        end else begin
          bip_acc <= bip_acc ^ scr_byte;
        end
        tx_byte_out.data <= all_zero_inject ? 8'h00 : scr_byte;
      end
    end
  end

  // checks
  sequence sect_write_s;
    clk_en_in && psel_in && penable_in && pwrite_in &&
    (paddr_in[7:2] == `IDX_SECT_ERR_LO || paddr_in[7:2] == `IDX_SECT_ERR_HI);
  endsequence

  sequence master_write_s;
    clk_en_in && psel_in && penable_in && pwrite_in && paddr_in[7:2] == `IDX_MASTER_LOAD;
  endsequence

  sect_snapshot_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    sect_write_s |=> section_parity_error_count == $past(sect_sum) && section_acc == 16'h0000)
    else $error("section snapshot wrong");

  master_load_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    master_write_s |=> line_parity_error_count == $past(b2_sum) &&
                       line_far_end_error_count == $past(febe_sum) &&
                       section_parity_error_count == $past(sect_sum))
    else $error("master load missed a counter");

  word_mode_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    clk_en_in && !line_poll && b2_word_count_mode && rx_event_in.b2_valid &&
    rx_event_in.b2_count != 5'h00 && line_acc < 20'hFFFFE |=> line_acc == $past(line_acc) + 20'h1)
    else $error("word mode count wrong");

  bit_mode_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    clk_en_in && !line_poll && !b2_word_count_mode && rx_event_in.b2_valid &&
    line_acc < 20'hFFF00 |=> line_acc == $past(line_acc) + {15'h0, $past(rx_event_in.b2_count)})
    else $error("bit mode count wrong");

  rdi_change_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    clk_en_in && rx_event_in.rdi_state != rdi_prev |=> irq_status.rdi)
    else $error("rdi change not flagged");

  irq_gate_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    ##1 irq_out == |(irq_status & irq_enable))
    else $error("interrupt does not follow enabled status");

  zero_force_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    clk_en_in && tx_byte_in.valid && all_zero_inject |=> tx_byte_out.data == 8'h00)
    else $error("stream not forced to zero");

  framing_bad_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    clk_en_in && tx_byte_in.valid && tx_slot_in.a1 && tx_slot_in.unscrambled &&
    !all_zero_inject |=> tx_byte_out.data == (framing_error_inject ? `A1_BAD : `A1_GOOD))
    else $error("framing byte value wrong");

  status_read_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    setup_rd && idx == `IDX_RX_LINE_CTL |=> prdata_out[0] == $past(rx_event_in.rdi_state))
    else $error("rdi state not reported");

endmodule : sonet_section_line_overhead_regs

`default_nettype wire
